// ---- bac_alu.sv ----
`timescale 1ns/10ps
// ****************************************************************
// decode and arithmetic for the three instructions
// ****************************************************************
module bac_alu (
   input wire logic [15:0] insn,
   input wire logic [7:0] opnd,
   input wire logic [7:0] acc,
   input wire bac_pkg::bac_flags_type flags_in,
   output bac_pkg::bac_alu_type res
);
   logic [4:0] lo_sum;
   logic [4:0] hi_sum;

   always_comb begin
      res = '0;
      res.flags = flags_in;
      lo_sum = {1'b0, acc[3:0]};
      hi_sum = '0;
      if (insn == bac_pkg::OP_ADJ) begin
         res.kind = bac_pkg::KIND_ADJ;
         res.to_acc = 1'b1;
         if ((acc[3:0] > bac_pkg::DIGIT_MAX) || flags_in.hc) begin
            lo_sum = {1'b0, acc[3:0]} + {1'b0, bac_pkg::BCD_ADJ};
         end
         // digit carry into the high digit is the low adjust carry
         if ((({1'b0, acc[7:4]} + {4'h0, lo_sum[4]}) > {1'b0, bac_pkg::DIGIT_MAX}) ||
             flags_in.c) begin
            hi_sum = {1'b0, acc[7:4]} + {1'b0, bac_pkg::BCD_ADJ} + {4'h0, lo_sum[4]};
         end else begin
            hi_sum = {1'b0, acc[7:4]} + {4'h0, lo_sum[4]};
         end
         res.result = {hi_sum[3:0], lo_sum[3:0]};
         res.flags.c = flags_in.c | hi_sum[4];
      end else if (insn[15:10] == bac_pkg::OP_DEC_HI) begin
         res.kind = bac_pkg::KIND_DEC;
         res.to_acc = ~insn[9];
         res.result = opnd - 8'h01;
         res.flags.c = (opnd != 8'h00);
         res.flags.hc = (opnd[3:0] != 4'h0);
         res.flags.z = (opnd == 8'h01);
         res.flags.n = res.result[7];
         res.flags.ov = (opnd == bac_pkg::SIGN_MIN);
      end else if (insn[15:9] == bac_pkg::OP_CMP_HI) begin
         res.kind = bac_pkg::KIND_CMP;
         res.less = (opnd < acc);
      end
   end
endmodule : bac_alu

// ---- bac_core.sv ----
// Operation
// - compare skips next instruction when file register is below accumulator, unsigned
// - compare takes one cycle, two when skipping, three over two-word instruction
// - skipped cycles idle in all quarters; compare itself writes nothing
// - decimal adjust adds six to low digit above nine or digit carry
// - high digit gets six plus digit carry above nine or carry set
// - decimal adjust has one fixed opcode and changes only carry
// - decimal adjust yields packed BCD accumulator in one cycle
// - decrement subtracts one; destination bit picks accumulator or register
// - bank bit zero picks access bank, one picks bank select register
// - indexed offset when bank bit zero, extended set on, address up to 95
`timescale 1ns/10ps
module bac_core #(
   parameter int ADDR_W = 12
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   localparam int BANK_W = ADDR_W - 8;
   localparam int DEPTH = 1 << ADDR_W;

   // ****************************************************************
   // state
   // ****************************************************************
   logic [7:0] mem [DEPTH];
   logic wait_ff, nxt_wait;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [1:0] ctrl_ff, nxt_ctrl;
   logic [15:0] insn_ff, nxt_insn;
   logic [7:0] acc_ff, nxt_acc;
   bac_pkg::bac_flags_type flags_ff, nxt_flags;
   logic [5:0] bank_ff, nxt_bank;
   logic [ADDR_W-1:0] maddr_ff, nxt_maddr;
   logic [ADDR_W-1:0] index_ff, nxt_index;
   logic [ADDR_W-1:0] ea_ff, nxt_ea;
   logic [7:0] opnd_ff, nxt_opnd;
   bac_pkg::bac_alu_type alu_ff, nxt_alu;
   logic skipped_ff, nxt_skipped;
   logic illegal_ff, nxt_illegal;
   logic [1:0] skip_ff, nxt_skip;
   logic mem_we;
   logic [ADDR_W-1:0] mem_wa;
   logic [7:0] mem_wd;
   logic [ADDR_W-1:0] ea;
   logic [31:0] wmask;
   logic [31:0] rmux;
   logic accept;
   logic finish;
   logic start;
   logic busy;
   bac_pkg::bac_alu_type alu_out;
   bac_pkg::bac_phase_type phase;
   logic first;
   logic [1:0] cycles;

   bac_alu u_alu (
      .insn(insn_ff),
      .opnd(opnd_ff),
      .acc(acc_ff),
      .flags_in(flags_ff),
      .res(alu_out)
   );

   bac_quarter u_quarter (
      .core_clk(core_clk),
      .reset(reset),
      .start(start),
      .skip_cycles(skip_ff),
      .phase(phase),
      .first(first),
      .cycles(cycles)
   );

   // ****************************************************************
   // operand address
   // ****************************************************************
   always_comb begin
      if (insn_ff[8]) begin
         ea = {bank_ff[BANK_W-1:0], insn_ff[7:0]};
      end else if (ctrl_ff[bac_pkg::CTRL_EXT] && insn_ff[7:0] <= bac_pkg::IDX_LIMIT) begin
         ea = index_ff + {{BANK_W{1'b0}}, insn_ff[7:0]};
      end else if (insn_ff[7:0] < bac_pkg::ACCESS_LOW) begin
         ea = {{BANK_W{1'b0}}, insn_ff[7:0]};
      end else begin
         ea = {{BANK_W{1'b1}}, insn_ff[7:0]};
      end
   end

   // ****************************************************************
   // bus slave and register file
   // ****************************************************************
   assign busy = (phase != bac_pkg::PH_IDLE);
   assign accept = (avs_read || avs_write) && wait_ff && !busy;
   assign finish = !wait_ff;
   assign start = finish && avs_write && avs_address == bac_pkg::OFS_INSN;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
      end
      unique case (avs_address)
         bac_pkg::OFS_CTRL: rmux = {30'h0, ctrl_ff};
         bac_pkg::OFS_INSN: rmux = {16'h0, insn_ff};
         bac_pkg::OFS_ACC: rmux = {24'h0, acc_ff};
         bac_pkg::OFS_FLAGS: rmux = {27'h0, flags_ff};
         bac_pkg::OFS_BANK: rmux = {26'h0, bank_ff};
         bac_pkg::OFS_STATE: rmux = {26'h0, cycles, 1'b0, illegal_ff, skipped_ff, busy};
         bac_pkg::OFS_MADDR: rmux = {{(32-ADDR_W){1'b0}}, maddr_ff};
         bac_pkg::OFS_MDATA: rmux = {24'h0, mem[maddr_ff]};
         bac_pkg::OFS_INDEX: rmux = {{(32-ADDR_W){1'b0}}, index_ff};
         default: rmux = 32'h0;
      endcase
   end

   always_comb begin
      logic [31:0] wv;
      wv = 32'h0;
      nxt_wait = wait_ff;
      nxt_rdata = rdata_ff;
      nxt_ctrl = ctrl_ff;
      nxt_insn = insn_ff;
      nxt_acc = acc_ff;
      nxt_flags = flags_ff;
      nxt_bank = bank_ff;
      nxt_maddr = maddr_ff;
      nxt_index = index_ff;
      nxt_ea = ea_ff;
      nxt_opnd = opnd_ff;
      nxt_alu = alu_ff;
      nxt_skipped = skipped_ff;
      nxt_illegal = illegal_ff;
      nxt_skip = skip_ff;
      mem_we = 1'b0;
      mem_wa = maddr_ff;
      mem_wd = 8'h00;
      if (accept) begin
         nxt_wait = 1'b0;
         nxt_rdata = rmux;
      end
      if (finish) begin
         nxt_wait = 1'b1;
         nxt_rdata = 32'h0;
      end
      if (finish && avs_write) begin
         unique case (avs_address)
            bac_pkg::OFS_CTRL: begin
               wv = (32'(ctrl_ff) & ~wmask) | (avs_writedata & wmask);
               nxt_ctrl = wv[1:0];
            end
            bac_pkg::OFS_INSN: begin
               wv = (32'(insn_ff) & ~wmask) | (avs_writedata & wmask);
               nxt_insn = wv[15:0];
               nxt_skipped = 1'b0;
               nxt_illegal = 1'b0;
               nxt_skip = 2'h0;
            end
            bac_pkg::OFS_ACC: begin
               wv = (32'(acc_ff) & ~wmask) | (avs_writedata & wmask);
               nxt_acc = wv[7:0];
            end
            bac_pkg::OFS_FLAGS: begin
               wv = (32'(flags_ff) & ~wmask) | (avs_writedata & wmask);
               nxt_flags = wv[4:0];
            end
            bac_pkg::OFS_BANK: begin
               wv = (32'(bank_ff) & ~wmask) | (avs_writedata & wmask);
               nxt_bank = wv[5:0];
            end
            bac_pkg::OFS_MADDR: begin
               wv = (32'(maddr_ff) & ~wmask) | (avs_writedata & wmask);
               nxt_maddr = wv[ADDR_W-1:0];
            end
            bac_pkg::OFS_MDATA: begin
               mem_we = avs_byteenable[0];
               mem_wd = avs_writedata[7:0];
            end
            bac_pkg::OFS_INDEX: begin
               wv = (32'(index_ff) & ~wmask) | (avs_writedata & wmask);
               nxt_index = wv[ADDR_W-1:0];
            end
            default: wv = 32'h0;
         endcase
      end
      // instruction execution; bus writes are stalled while busy
      if (first) begin
         unique case (phase)
            bac_pkg::PH_Q2: begin
               nxt_ea = ea;
               nxt_opnd = (alu_out.kind == bac_pkg::KIND_ADJ) ? acc_ff : mem[ea];
            end
            bac_pkg::PH_Q3: nxt_alu = alu_out;
            bac_pkg::PH_Q4: begin
               unique case (alu_ff.kind)
                  bac_pkg::KIND_ADJ: begin
                     nxt_acc = alu_ff.result;
                     nxt_flags = alu_ff.flags;
                  end
                  bac_pkg::KIND_DEC: begin
                     nxt_flags = alu_ff.flags;
                     if (alu_ff.to_acc) begin
                        nxt_acc = alu_ff.result;
                     end else begin
                        mem_we = 1'b1;
                        mem_wa = ea_ff;
                        mem_wd = alu_ff.result;
                     end
                  end
                  bac_pkg::KIND_CMP: begin
                     // no write; only the skip decision
                     nxt_skipped = alu_ff.less;
                  end
                  bac_pkg::KIND_NONE: nxt_illegal = 1'b1;
               endcase
            end
            default: nxt_skip = skip_ff;
         endcase
      end
      if (first && phase == bac_pkg::PH_Q3) begin
         nxt_skip = 2'h0;
         if (alu_out.kind == bac_pkg::KIND_CMP && alu_out.less) begin
            nxt_skip = ctrl_ff[bac_pkg::CTRL_TWO] ? 2'h2 : 2'h1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         wait_ff <= 1'b1;
         rdata_ff <= 32'h0;
         ctrl_ff <= bac_pkg::CTRL_RST;
         insn_ff <= bac_pkg::INSN_RST;
         acc_ff <= bac_pkg::ACC_RST;
         flags_ff <= bac_pkg::FLAGS_RST;
         bank_ff <= 6'h00;
         maddr_ff <= '0;
         index_ff <= '0;
         ea_ff <= '0;
         opnd_ff <= 8'h00;
         alu_ff <= '0;
         skipped_ff <= 1'b0;
         illegal_ff <= 1'b0;
         skip_ff <= 2'h0;
      end else begin
         wait_ff <= nxt_wait;
         rdata_ff <= nxt_rdata;
         ctrl_ff <= nxt_ctrl;
         insn_ff <= nxt_insn;
         acc_ff <= nxt_acc;
         flags_ff <= nxt_flags;
         bank_ff <= nxt_bank;
         maddr_ff <= nxt_maddr;
         index_ff <= nxt_index;
         ea_ff <= nxt_ea;
         opnd_ff <= nxt_opnd;
         alu_ff <= nxt_alu;
         skipped_ff <= nxt_skipped;
         illegal_ff <= nxt_illegal;
         skip_ff <= nxt_skip;
      end
   end

   always_ff @(posedge core_clk) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   assign avs_readdata = rdata_ff;
   assign avs_waitrequest = wait_ff;

   // ****************************************************************
   // checks
   // ****************************************************************
   skip_idle_a: assert property (@(posedge core_clk) disable iff (reset)
      (busy && !first) |-> !mem_we && $stable(acc_ff) && $stable(flags_ff))
      else $error("skip cycle changed state");
   cycle_count_a: assert property (@(posedge core_clk) disable iff (reset)
      ($fell(busy) && alu_ff.kind == bac_pkg::KIND_CMP) |->
      cycles == (alu_ff.less ? (ctrl_ff[bac_pkg::CTRL_TWO] ? 2'h3 : 2'h2) : 2'h1))
      else $error("compare cycle count wrong");
   first_len_a: assert property (@(posedge core_clk) disable iff (reset)
      start |=> first [*4] ##1 !first)
      else $error("instruction cycle not four quarters");
   cmp_nowrite_a: assert property (@(posedge core_clk) disable iff (reset)
      (first && phase == bac_pkg::PH_Q4 && alu_ff.kind == bac_pkg::KIND_CMP) |->
      !mem_we ##1 $stable(acc_ff) && $stable(flags_ff))
      else $error("compare wrote a result");
   adj_flags_a: assert property (@(posedge core_clk) disable iff (reset)
      (first && phase == bac_pkg::PH_Q4 && alu_ff.kind == bac_pkg::KIND_ADJ) |=>
      flags_ff.n == $past(flags_ff.n) && flags_ff.z == $past(flags_ff.z) &&
      flags_ff.ov == $past(flags_ff.ov) && flags_ff.hc == $past(flags_ff.hc))
      else $error("decimal adjust touched other flags");
   adj_low_a: assert property (@(posedge core_clk) disable iff (reset)
      (first && phase == bac_pkg::PH_Q3 && alu_out.kind == bac_pkg::KIND_ADJ &&
      !flags_ff.hc && acc_ff[3:0] <= bac_pkg::DIGIT_MAX) |=>
      ##1 acc_ff[3:0] == $past(acc_ff[3:0], 2))
      else $error("low digit changed without need");
   dec_acc_a: assert property (@(posedge core_clk) disable iff (reset)
      (first && phase == bac_pkg::PH_Q4 && alu_ff.kind == bac_pkg::KIND_DEC &&
      !insn_ff[9]) |=> acc_ff == $past(opnd_ff) - 8'h01)
      else $error("decrement to accumulator wrong");
   dec_mem_a: assert property (@(posedge core_clk) disable iff (reset)
      (first && phase == bac_pkg::PH_Q4 && alu_ff.kind == bac_pkg::KIND_DEC &&
      insn_ff[9]) |-> mem_we && mem_wa == ea_ff && mem_wd == opnd_ff - 8'h01)
      else $error("decrement to register wrong");
   bank_sel_a: assert property (@(posedge core_clk) disable iff (reset)
      insn_ff[8] |-> ea[7:0] == insn_ff[7:0] && ea[ADDR_W-1:8] == bank_ff[BANK_W-1:0])
      else $error("banked address wrong");
   index_sel_a: assert property (@(posedge core_clk) disable iff (reset)
      (!insn_ff[8] && ctrl_ff[bac_pkg::CTRL_EXT] && insn_ff[7:0] <= bac_pkg::IDX_LIMIT) |->
      ea == index_ff + {{BANK_W{1'b0}}, insn_ff[7:0]})
      else $error("indexed address wrong");
   skip_flag_a: assert property (@(posedge core_clk) disable iff (reset)
      (first && phase == bac_pkg::PH_Q2 && insn_ff[15:9] == bac_pkg::OP_CMP_HI) |=>
      ##2 skipped_ff == ($past(opnd_ff, 2) < acc_ff))
      else $error("compare skip decision wrong");
   dec_zero_a: assert property (@(posedge core_clk) disable iff (reset)
      (first && phase == bac_pkg::PH_Q4 && alu_ff.kind == bac_pkg::KIND_DEC) |=>
      flags_ff.z == ($past(opnd_ff) == 8'h01) && flags_ff.c == ($past(opnd_ff) != 8'h00))
      else $error("decrement flags wrong");
endmodule : bac_core

// ---- bac_pkg.sv ----
// ****************************************************************
// shared constants and types
// ****************************************************************
package bac_pkg;
   // register byte offsets
   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_INSN = 6'h04;
   localparam logic [5:0] OFS_ACC = 6'h08;
   localparam logic [5:0] OFS_FLAGS = 6'h0c;
   localparam logic [5:0] OFS_BANK = 6'h10;
   localparam logic [5:0] OFS_STATE = 6'h14;
   localparam logic [5:0] OFS_MADDR = 6'h18;
   localparam logic [5:0] OFS_MDATA = 6'h1c;
   localparam logic [5:0] OFS_INDEX = 6'h20;
   // control bit positions
   localparam int CTRL_EXT = 0;
   localparam int CTRL_TWO = 1;
   // reset values
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [4:0] FLAGS_RST = 5'h00;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [15:0] INSN_RST = 16'h0000;
   // opcodes
   localparam logic [15:0] OP_ADJ = 16'h0007;
   localparam logic [5:0] OP_DEC_HI = 6'h01;
   localparam logic [6:0] OP_CMP_HI = 7'h30;
   // arithmetic and addressing constants
   localparam logic [3:0] DIGIT_MAX = 4'h9;
   localparam logic [3:0] BCD_ADJ = 4'h6;
   localparam logic [7:0] IDX_LIMIT = 8'h5f;
   localparam logic [7:0] ACCESS_LOW = 8'h60;
   localparam logic [7:0] SIGN_MIN = 8'h80;

   typedef enum logic [1:0] {KIND_NONE, KIND_CMP, KIND_ADJ, KIND_DEC} bac_kind_type;
   typedef enum logic [2:0] {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4} bac_phase_type;
   typedef struct packed {
      logic n;
      logic ov;
      logic z;
      logic hc;
      logic c;
   } bac_flags_type;
   typedef struct packed {
      bac_kind_type kind;
      logic [7:0] result;
      bac_flags_type flags;
      logic to_acc;
      logic less;
   } bac_alu_type;
endpackage : bac_pkg

// ---- bac_quarter.sv ----
`timescale 1ns/10ps
// ****************************************************************
// quarter phase sequencer with idle skip cycles
// ****************************************************************
module bac_quarter (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic start,
   input wire logic [1:0] skip_cycles,
   output bac_pkg::bac_phase_type phase,
   output logic first,
   output logic [1:0] cycles
);
   bac_pkg::bac_phase_type phase_ff, nxt_phase;
   logic first_ff, nxt_first;
   logic [1:0] left_ff, nxt_left;
   logic [1:0] cyc_ff, nxt_cyc;

   always_comb begin
      nxt_phase = phase_ff;
      nxt_first = first_ff;
      nxt_left = left_ff;
      nxt_cyc = cyc_ff;
      unique case (phase_ff)
         bac_pkg::PH_IDLE: begin
            if (start) begin
               nxt_phase = bac_pkg::PH_Q1;
               nxt_first = 1'b1;
               nxt_cyc = 2'h1;
            end
         end
         bac_pkg::PH_Q1: nxt_phase = bac_pkg::PH_Q2;
         bac_pkg::PH_Q2: nxt_phase = bac_pkg::PH_Q3;
         bac_pkg::PH_Q3: nxt_phase = bac_pkg::PH_Q4;
         bac_pkg::PH_Q4: begin
            nxt_first = 1'b0;
            if (first_ff && skip_cycles != 2'h0) begin
               nxt_left = skip_cycles - 2'h1;
               nxt_phase = bac_pkg::PH_Q1;
               nxt_cyc = cyc_ff + 2'h1;
            end else if (!first_ff && left_ff != 2'h0) begin
               nxt_left = left_ff - 2'h1;
               nxt_phase = bac_pkg::PH_Q1;
               nxt_cyc = cyc_ff + 2'h1;
            end else begin
               nxt_phase = bac_pkg::PH_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         phase_ff <= bac_pkg::PH_IDLE;
         first_ff <= 1'b0;
         left_ff <= 2'h0;
         cyc_ff <= 2'h0;
      end else begin
         phase_ff <= nxt_phase;
         first_ff <= nxt_first;
         left_ff <= nxt_left;
         cyc_ff <= nxt_cyc;
      end
   end

   assign phase = phase_ff;
   assign first = first_ff;
   assign cycles = cyc_ff;
endmodule : bac_quarter

// ---- test_bcd_adjust_compare_decrement.sv ----
`timescale 1ns/10ps
// ****************************************************************
// bench: register bus driver and shared checks
// ****************************************************************
module test_bcd_adjust_compare_decrement;
   logic core_clk;
   logic reset;
   logic [5:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   int miscompares;
   int num_checks;
   int last_wait;
   int base_wait;
   logic [31:0] rd;

   bac_core #(.ADDR_W(12)) i_dut (
      .core_clk(core_clk),
      .reset(reset),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest)
   );

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // one transfer; waits stall while an instruction runs, counted in last_wait
   task automatic bus(input logic we, input logic [5:0] addr, input logic [31:0] wdata);
      @(posedge core_clk);
      avs_address <= addr;
      avs_read <= ~we;
      avs_write <= we;
      avs_writedata <= wdata;
      last_wait = 0;
      // waitrequest and read data are taken as they stand at the rising edge
      do begin
         @(posedge core_clk);
         last_wait++;
      end while (avs_waitrequest !== 1'b0 && last_wait < 100);
      if (avs_waitrequest !== 1'b0) begin
         miscompares++;
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rdc(input string name, input logic [5:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(name, rd, exp);
   endtask : rdc

   function automatic logic [8:0] adj_exp(input logic [7:0] w, input logic hc, input logic c);
      logic [4:0] lo;
      logic [4:0] hi;
      lo = {1'b0, w[3:0]};
      if (w[3:0] > 4'h9 || hc) begin
         lo = lo + 5'h06;
      end
      hi = {1'b0, w[7:4]} + {4'h0, lo[4]};
      if (hi > 5'h09 || c) begin
         hi = hi + 5'h06;
      end
      return {c | hi[4], hi[3:0], lo[3:0]};
   endfunction : adj_exp

   function automatic logic [4:0] dec_flags(input logic [7:0] v);
      logic [7:0] r;
      r = v - 8'h01;
      return {r[7], v == 8'h80, r == 8'h00, v[3:0] != 4'h0, v != 8'h00};
   endfunction : dec_flags

// ****************************************************************
// scenarios
// ****************************************************************
   task automatic test_reset;
      rdc("acc", bac_pkg::OFS_ACC, {24'h0, bac_pkg::ACC_RST});
      rdc("flags", bac_pkg::OFS_FLAGS, {27'h0, bac_pkg::FLAGS_RST});
      rdc("state", bac_pkg::OFS_STATE, 32'h0);
      wr(6'h24, 32'hffff_ffff);
      rdc("unmapped", 6'h24, 32'h0);
      $display("test reset done");
   endtask : test_reset

   task automatic test_adj;
      logic [7:0] w [6] = '{8'ha5, 8'hce, 8'h99, 8'h0a, 8'h19, 8'h12};
      logic [1:0] fl [6] = '{2'b00, 2'b00, 2'b00, 2'b01, 2'b10, 2'b01};
      logic [8:0] e;
      for (int i = 0; i < 6; i++) begin
         e = adj_exp(w[i], fl[i][1], fl[i][0]);
         wr(bac_pkg::OFS_FLAGS, {27'h0, 3'b101, fl[i]});
         wr(bac_pkg::OFS_ACC, {24'h0, w[i]});
         wr(bac_pkg::OFS_INSN, {16'h0, bac_pkg::OP_ADJ});
         rdc("adj acc", bac_pkg::OFS_ACC, {24'h0, e[7:0]});
         base_wait = last_wait;
         rdc("adj flags", bac_pkg::OFS_FLAGS, {27'h0, 3'b101, fl[i][1], e[8]});
         rdc("adj state", bac_pkg::OFS_STATE, 32'h10);
      end
      // a neighbouring opcode must not adjust
      wr(bac_pkg::OFS_INSN, 32'h0000_0006);
      rdc("near opcode acc", bac_pkg::OFS_ACC, {24'h0, e[7:0]});
      bus(1'b0, bac_pkg::OFS_STATE, 32'h0);
      check("near opcode state", rd & 32'h4, 32'h4);
      $display("test decimal adjust done");
   endtask : test_adj

   task automatic dec_case(input logic d, input logic a, input logic ext, input logic [7:0] f,
                           input logic [11:0] addr, input logic [7:0] v);
      wr(bac_pkg::OFS_CTRL, {31'h0, ext});
      wr(bac_pkg::OFS_MADDR, {20'h0, addr});
      wr(bac_pkg::OFS_MDATA, {24'h0, v});
      wr(bac_pkg::OFS_ACC, 32'h0000_00c3);
      wr(bac_pkg::OFS_FLAGS, 32'h0);
      wr(bac_pkg::OFS_INSN, {16'h0, bac_pkg::OP_DEC_HI, d, a, f});
      rdc("dec acc", bac_pkg::OFS_ACC, d ? 32'hc3 : {24'h0, v - 8'h01});
      rdc("dec mem", bac_pkg::OFS_MDATA, {24'h0, d ? v - 8'h01 : v});
      rdc("dec flags", bac_pkg::OFS_FLAGS, {27'h0, dec_flags(v)});
      rdc("dec state", bac_pkg::OFS_STATE, 32'h10);
   endtask : dec_case

   task automatic test_dec;
      wr(bac_pkg::OFS_BANK, 32'h3);
      wr(bac_pkg::OFS_INDEX, 32'h200);
      dec_case(1'b1, 1'b1, 1'b1, 8'h40, 12'h340, 8'h80);
      dec_case(1'b0, 1'b0, 1'b0, 8'h40, 12'h040, 8'h00);
      dec_case(1'b1, 1'b0, 1'b1, 8'h10, 12'h210, 8'h01);
      dec_case(1'b1, 1'b0, 1'b1, 8'h5f, 12'h25f, 8'h10);
      dec_case(1'b0, 1'b0, 1'b1, 8'h60, 12'hf60, 8'h7f);
      dec_case(1'b1, 1'b0, 1'b0, 8'h9f, 12'hf9f, 8'h5a);
      $display("test decrement done");
   endtask : test_dec

   task automatic cmp_case(input logic two, input logic [7:0] w, input logic [7:0] v);
      logic skip;
      skip = v < w;
      wr(bac_pkg::OFS_CTRL, {30'h0, two, 1'b0});
      wr(bac_pkg::OFS_MADDR, 32'h345);
      wr(bac_pkg::OFS_MDATA, {24'h0, v});
      wr(bac_pkg::OFS_ACC, {24'h0, w});
      wr(bac_pkg::OFS_FLAGS, 32'h15);
      wr(bac_pkg::OFS_INSN, {16'h0, bac_pkg::OP_CMP_HI, 1'b1, 8'h45});
      rdc("cmp acc", bac_pkg::OFS_ACC, {24'h0, w});
      check("cmp wait", 32'(last_wait), 32'(base_wait + (skip ? (two ? 8 : 4) : 0)));
      rdc("cmp mem", bac_pkg::OFS_MDATA, {24'h0, v});
      rdc("cmp flags", bac_pkg::OFS_FLAGS, 32'h15);
      rdc("cmp state", bac_pkg::OFS_STATE, skip ? (two ? 32'h32 : 32'h22) : 32'h10);
   endtask : cmp_case

   task automatic test_cmp;
      cmp_case(1'b0, 8'h80, 8'h7f);
      cmp_case(1'b0, 8'h40, 8'h40);
      cmp_case(1'b0, 8'h10, 8'hf0);
      cmp_case(1'b1, 8'h05, 8'h04);
      cmp_case(1'b1, 8'h04, 8'h05);
      $display("test compare done");
   endtask : test_cmp

   initial begin
      reset = 1'b1;
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      miscompares = 0;
      num_checks = 0;
      repeat (6) @(posedge core_clk);
      reset <= 1'b0;
      test_reset;
      test_adj;
      test_dec;
      test_cmp;
      end_sim;
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      end_sim;
   end
endmodule : test_bcd_adjust_compare_decrement
